// ### exc_ctrl.sv
// exception controller: pending/active tracking, arbitration, stacking, vector fetch, return
// assumes the pipeline supplies frame data on pushes and takes entry at instruction boundaries
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "exc_params.svh"
module exc_ctrl (
  input  wire logic              aclk,         // core clock
  input  wire logic              aresetn,      // synchronous reset, low
  input  wire logic [31:0]       awaddr,       // write address
  input  wire logic [2:0]        awprot,       // bit0 set: privileged
  input  wire logic              awvalid,      // write address valid
  output wire logic              awready,      // write address ready
  input  wire logic [31:0]       wdata,        // write data
  input  wire logic [3:0]        wstrb,        // byte strobes
  input  wire logic              wvalid,       // write data valid
  output wire logic              wready,       // write data ready
  output      logic [1:0]        bresp,        // write response
  output      logic              bvalid,       // write response valid
  input  wire logic              bready,       // write response ready
  input  wire logic [31:0]       araddr,       // read address
  input  wire logic [2:0]        arprot,       // read protection
  input  wire logic              arvalid,      // read address valid
  output wire logic              arready,      // read address ready
  output      logic [31:0]       rdata,        // read data
  output      logic [1:0]        rresp,        // read response
  output      logic              rvalid,       // read valid
  input  wire logic              rready,       // read ready
  input  wire logic [31:0]       irq,          // peripheral requests, level
  input  wire logic              nmi_req,      // non-maskable request
  input  wire logic              fault_req,    // unrecoverable fault, sync
  input  wire logic              svc_req,      // supervisor call instruction
  input  wire logic              tick_req,     // tick timer reached zero
  output wire logic              take_req,     // entry wanted
  input  wire logic              take_ack,     // pipeline at a boundary
  input  wire logic              ret_req,      // pop to pc or indirect branch
  input  wire logic [31:0]       ret_value,    // value loaded to program counter
  input  wire logic [31:0]       msp_in,       // main stack pointer
  input  wire logic [31:0]       psp_in,       // process stack pointer
  output wire logic              mem_valid,    // frame or vector access
  output wire exc_pkg::mem_req_s mem_req,      // access kind and address
  input  wire logic              mem_ready,    // access done
  input  wire logic [31:0]       mem_rdata,    // vector read data
  output      logic              pc_load,      // load handler address
  output      logic [31:0]       pc_value,     // handler address
  output      logic              lr_we,        // write link register
  output      logic [31:0]       lr_value,     // return token
  output      logic              sp_we,        // update stack pointer
  output      exc_pkg::sp_upd_s  sp_upd,       // which stack and value
  output      logic              ret_done,     // unstacking finished
  output wire logic              handler_mode, // an exception is active
  output wire logic              priv,         // privileged execution
  output wire logic              use_psp,      // thread uses process stack
  output wire logic [5:0]        cur_exc       // current exception number
);
  localparam int N = `EXC_NUM;

  exc_pkg::state_e st_q, st_d;
  logic [5:0]      sel_q, sel_d;
  logic [2:0]      srank_q, srank_d, cnt_q, cnt_d;
  logic [31:0]     frame_q, frame_d, tok_q, tok_d;
  logic            psp_q, psp_d;
  logic [N-1:0]    pend_q, act_q, pset, pclr, aset, aclr;
  logic [31:0]     irq_en_q, sw_set, sw_clr;
  logic [2:0]      sys_en_q;
  logic [1:0]      svc_pr_q, def_pr_q, tick_pr_q, def_sw;
  logic [31:0][1:0] irq_pr_q;
  logic [23:0]     tbl_q;
  logic            mask_q;
  logic [2:0]      rank [N];
  logic [N-1:0]    elig;
  logic [2:0]      best_rank, cur_rank, rest_rank;
  logic [5:0]      best_num, cur_num;

  // rank 0..5, lower is more urgent; ties keep the lower number
  always_comb begin
    best_rank = `RANK_NONE;
    best_num  = 6'h00;
    cur_rank  = `RANK_NONE;
    cur_num   = 6'h00;
    rest_rank = `RANK_NONE;
    for (int i = 0; i < N; i++) begin
      rank[i] = `RANK_NONE;
      elig[i] = 1'b0;
      if (i == `EXC_NMI) begin
        rank[i] = `RANK_NMI;
        elig[i] = pend_q[i];
      end else if (i == `EXC_FAULT) begin
        rank[i] = `RANK_FAULT;
        elig[i] = pend_q[i];
      end else if (i == `EXC_SVC) begin
        rank[i] = `RANK_CFG + {1'b0, svc_pr_q};
        elig[i] = pend_q[i] & sys_en_q[0];
      end else if (i == `EXC_DEFER) begin
        rank[i] = `RANK_CFG + {1'b0, def_pr_q};
        elig[i] = pend_q[i] & sys_en_q[1];
      end else if (i == `EXC_TICK) begin
        rank[i] = `RANK_CFG + {1'b0, tick_pr_q};
        elig[i] = pend_q[i] & sys_en_q[2];
      end else if (i >= `IRQ_BASE) begin
        rank[i] = `RANK_CFG + {1'b0, irq_pr_q[i-`IRQ_BASE]};
        elig[i] = pend_q[i] & irq_en_q[i-`IRQ_BASE];
      end
      if (elig[i] && rank[i] < best_rank) begin
        best_rank = rank[i];
        best_num  = 6'(i);
      end
      if (act_q[i] && rank[i] < cur_rank) begin
        cur_rank = rank[i];
        cur_num  = 6'(i);
      end
    end
    for (int i = 0; i < N; i++) begin
      if (act_q[i] && 6'(i) != cur_num && rank[i] < rest_rank) rest_rank = rank[i];
    end
  end

  wire mask_ok  = (best_rank < `RANK_CFG) || !mask_q;
  wire entry_ok = mask_ok && (best_rank < cur_rank);
  wire tail_ok  = mask_ok && (best_rank < rest_rank);
  wire late_ok  = mask_ok && (best_rank < srank_q);
  wire ret_hit  = (st_q == exc_pkg::ST_RUN) && ret_req && handler_mode &&
                  (ret_value[31:4] == `TOK_TOP);
  wire tok_ok   = (ret_value == `TOK_HANDLER) || (ret_value == `TOK_MAIN) ||
                  (ret_value == `TOK_PROC);
  wire [31:0] cur_sp   = psp_q ? psp_in : msp_in;
  wire [31:0] push_bot = (cur_sp - `FRAME_BYTES) & 32'hFFFF_FFF8;
  wire [31:0] tbl_base = {tbl_q, 8'h00};
  wire        mem_done = mem_valid && mem_ready;
  wire        vec_done = (st_q == exc_pkg::ST_VEC) && mem_ready;

  assign handler_mode = |act_q;
  assign cur_exc      = handler_mode ? cur_num : 6'h00;
  assign use_psp      = psp_q;
  assign priv         = 1'b1;
  assign take_req     = (st_q == exc_pkg::ST_RUN) && !ret_hit && entry_ok;
  assign mem_valid    = (st_q != exc_pkg::ST_RUN);
  assign mem_req.kind = (st_q == exc_pkg::ST_STACK)   ? exc_pkg::MEM_PUSH :
                        (st_q == exc_pkg::ST_UNSTACK) ? exc_pkg::MEM_POP : exc_pkg::MEM_VEC;
  assign mem_req.addr = (st_q == exc_pkg::ST_RESET) ? tbl_base + `VEC_RESET :
                        (st_q == exc_pkg::ST_VEC)   ? tbl_base + {24'h00_0000, sel_q, 2'b00} :
                        frame_q + {27'h000_0000, cnt_q, 2'b00};

  // set wins over clear, so a request during service leaves it active and pending
  assign pset = {irq, tick_req, def_sw[0], 2'b00, svc_req, 7'h00, fault_req | (ret_hit & !tok_ok),
                 nmi_req, 2'b00} | {sw_set, 16'h0000};
  assign pclr = ({N{vec_done}} & (N'(1) << sel_q)) | {sw_clr, 1'b0, def_sw[1], 14'h0000};
  assign aset = {N{vec_done}} & (N'(1) << sel_q);
  assign aclr = {N{ret_hit & tok_ok}} & (N'(1) << cur_num);

  always_comb begin
    st_d    = st_q;
    sel_d   = sel_q;
    srank_d = srank_q;
    cnt_d   = cnt_q;
    frame_d = frame_q;
    tok_d   = tok_q;
    psp_d   = psp_q;
    case (st_q)
      exc_pkg::ST_RESET: if (mem_ready) st_d = exc_pkg::ST_RUN;
      exc_pkg::ST_RUN: begin
        if (ret_hit && tok_ok) begin
          tok_d = (rest_rank != `RANK_NONE) ? `TOK_HANDLER : ret_value;
          if (best_rank != `RANK_NONE && tail_ok) begin
            sel_d   = best_num;
            srank_d = best_rank;
            st_d    = exc_pkg::ST_VEC;
          end else begin
            frame_d = ret_value[2] ? psp_in : msp_in;
            cnt_d   = 3'h0;
            st_d    = exc_pkg::ST_UNSTACK;
          end
        end else if (take_req && take_ack) begin
          sel_d   = best_num;
          srank_d = best_rank;
          frame_d = push_bot;
          cnt_d   = 3'h0;
          tok_d   = handler_mode ? `TOK_HANDLER : (psp_q ? `TOK_PROC : `TOK_MAIN);
          st_d    = exc_pkg::ST_STACK;
        end
      end
      exc_pkg::ST_STACK: begin
        if (best_rank != `RANK_NONE && late_ok) begin
          sel_d   = best_num;
          srank_d = best_rank;
        end
        if (mem_ready) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `FRAME_LAST) st_d = exc_pkg::ST_VEC;
        end
      end
      exc_pkg::ST_VEC: if (mem_ready) begin
        psp_d = 1'b0;
        st_d  = exc_pkg::ST_RUN;
      end
      exc_pkg::ST_UNSTACK: if (mem_ready) begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `FRAME_LAST) begin
          psp_d = tok_q[2];
          st_d  = exc_pkg::ST_RUN;
        end
      end
      default: st_d = exc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= exc_pkg::ST_RESET;
      sel_q   <= 6'h00;
      srank_q <= `RANK_NONE;
      cnt_q   <= 3'h0;
      frame_q <= 32'h0000_0000;
      tok_q   <= 32'h0000_0000;
      psp_q   <= 1'b0;
      pend_q  <= '0;
      act_q   <= '0;
    end else begin
      st_q    <= st_d;
      sel_q   <= sel_d;
      srank_q <= srank_d;
      cnt_q   <= cnt_d;
      frame_q <= frame_d;
      tok_q   <= tok_d;
      psp_q   <= psp_d;
      pend_q  <= (pend_q & ~pclr) | pset;
      act_q   <= (act_q & ~aclr) | aset;
    end
  end

  // pipeline strobes
  wire stack_end = (st_q == exc_pkg::ST_STACK) && mem_ready && (cnt_q == `FRAME_LAST);
  wire pop_end   = (st_q == exc_pkg::ST_UNSTACK) && mem_ready && (cnt_q == `FRAME_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_load  <= 1'b0;
      pc_value <= 32'h0000_0000;
      lr_we    <= 1'b0;
      lr_value <= 32'h0000_0000;
      sp_we    <= 1'b0;
      sp_upd   <= '0;
      ret_done <= 1'b0;
    end else begin
      pc_load  <= mem_done && (st_q == exc_pkg::ST_RESET || st_q == exc_pkg::ST_VEC);
      pc_value <= mem_done ? mem_rdata : pc_value;
      lr_we    <= vec_done;
      lr_value <= vec_done ? tok_q : lr_value;
      sp_we    <= stack_end || pop_end;
      sp_upd   <= stack_end ? '{process_stack_pointer: psp_q, value: frame_q} :
                  pop_end   ? '{process_stack_pointer: tok_q[2], value: frame_q + `FRAME_BYTES} : sp_upd;
      ret_done <= pop_end;
    end
  end

  // register slave: address and data accepted in either order, answered when both held
  logic        aw_q, w_q, wprot_q;
  logic [7:0]  wa_q;
  logic [31:0] wd_q, rd_mux;
  logic [3:0]  ws_q;
  logic        rd_hit;
  assign awready = !aw_q && !bvalid;
  assign wready  = !w_q && !bvalid;
  assign arready = !rvalid;
  wire        do_wr = aw_q && w_q && !bvalid;
  wire [31:0] wm    = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [31:0] wb    = wd_q & wm;
  wire        wr_ok = wprot_q && ((wa_q <= `OFF_STATUS) || (wa_q >= `OFF_IRQ_PRIO && wa_q <= `OFF_PRIO_END)) &&
                      (wa_q[1:0] == 2'b00);
  wire        wr_en   = do_wr && wr_ok && (wa_q == `OFF_IRQ_EN);
  wire        wr_sys  = do_wr && wr_ok && (wa_q == `OFF_SYS_CTRL);
  wire        wr_prio = do_wr && wr_ok && (wa_q >= `OFF_IRQ_PRIO);
  wire [2:0]  pr_word = 3'(wa_q[4:2]);
  assign sw_set = (do_wr && wr_ok && wa_q == `OFF_PEND_SET) ? wb : 32'h0000_0000;
  assign sw_clr = (do_wr && wr_ok && wa_q == `OFF_PEND_CLR) ? wb : 32'h0000_0000;
  assign def_sw = wr_sys ? wb[1:0] : 2'b00;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (araddr[7:0] == `OFF_IRQ_EN) rd_mux = irq_en_q;
    else if (araddr[7:0] == `OFF_PEND_SET || araddr[7:0] == `OFF_PEND_CLR) rd_mux = pend_q[N-1:16];
    else if (araddr[7:0] == `OFF_ACTIVE) rd_mux = act_q[N-1:16];
    else if (araddr[7:0] == `OFF_SYS_CTRL) rd_mux = {27'h000_0000, pend_q[15], pend_q[14], pend_q[11],
                                                     pend_q[3], pend_q[2]};
    else if (araddr[7:0] == `OFF_SYS_EN) rd_mux = {29'h0000_0000, sys_en_q};
    else if (araddr[7:0] == `OFF_SYS_PRIO) rd_mux = {8'h00, tick_pr_q, 6'h00, def_pr_q, 6'h00, svc_pr_q, 6'h00};
    else if (araddr[7:0] == `OFF_TABLE) rd_mux = tbl_base;
    else if (araddr[7:0] == `OFF_MASK) rd_mux = {31'h0000_0000, mask_q};
    else if (araddr[7:0] == `OFF_STATUS) rd_mux = {24'h00_0000, psp_q, handler_mode, cur_exc};
    else if (araddr[7:0] >= `OFF_IRQ_PRIO && araddr[7:0] <= `OFF_PRIO_END && araddr[1:0] == 2'b00)
      for (int b = 0; b < 4; b++) rd_mux[8*b+`PR_LSB +: 2] = irq_pr_q[{araddr[4:2], 2'(b)}];
    else rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_q, w_q, wprot_q, bvalid, rvalid} <= 5'h00;
      {wa_q, wd_q, ws_q, bresp, rresp, rdata} <= '0;
    end else begin
      if (awvalid && awready) {aw_q, wa_q, wprot_q} <= {1'b1, awaddr[7:0], awprot[0]};
      if (wvalid && wready) {w_q, wd_q, ws_q} <= {1'b1, wdata, wstrb};
      if (do_wr) {aw_q, w_q, bvalid, bresp} <= {3'b001, wr_ok ? `RESP_OK : `RESP_ERR};
      else if (bvalid && bready) bvalid <= 1'b0;
      if (arvalid && arready) {rvalid, rdata, rresp} <= {1'b1, rd_mux, (rd_hit && arprot[0]) ? `RESP_OK : `RESP_ERR};
      else if (rvalid && rready) rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 32'h0000_0000;
      sys_en_q <= 3'h0;
      {svc_pr_q, def_pr_q, tick_pr_q} <= 6'h00;
      irq_pr_q <= '0;
      tbl_q    <= `TBL_RST;
      mask_q   <= 1'b0;
    end else begin
      if (wr_en) irq_en_q <= (irq_en_q & ~wm) | wb;
      if (do_wr && wr_ok && wa_q == `OFF_SYS_EN && ws_q[0]) sys_en_q <= wd_q[2:0];
      if (do_wr && wr_ok && wa_q == `OFF_SYS_PRIO) begin
        if (ws_q[0]) svc_pr_q <= wd_q[7:6];
        if (ws_q[1]) def_pr_q <= wd_q[15:14];
        if (ws_q[2]) tick_pr_q <= wd_q[23:22];
      end
      if (do_wr && wr_ok && wa_q == `OFF_TABLE) tbl_q <= (tbl_q & ~wm[31:8]) | wb[31:8];
      if (do_wr && wr_ok && wa_q == `OFF_MASK && ws_q[0]) mask_q <= wd_q[0];
      for (int b = 0; b < 4; b++)
        if (wr_prio && ws_q[b]) irq_pr_q[{pr_word, 2'(b)}] <= wd_q[8*b+`PR_LSB +: 2];
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_keep_pending: assert property ((act_q[N-1:16] & irq) != 32'h0000_0000 |=>
    (pend_q[N-1:16] & $past(act_q[N-1:16] & irq)) == $past(act_q[N-1:16] & irq)) else $error("request lost");
  a_reset_vector: assert property (st_q == exc_pkg::ST_RESET |-> mem_req.addr == 32'h0000_0004)
    else $error("bad reset fetch");
  a_nmi_wins: assert property (pend_q[2] && !act_q[2] && take_req |-> best_num == 6'h02)
    else $error("nmi lost priority");
  a_vector_addr: assert property (st_q == exc_pkg::ST_VEC |-> mem_req.addr[7:0] == {sel_q, 2'b00})
    else $error("bad vector address");
  a_strict_preempt: assert property (vec_done |-> rank[sel_q] < cur_rank) else $error("equal preempted");
  a_mask_limit: assert property (mask_q && take_req |-> best_rank < 3'h2) else $error("mask ignored");
  a_eight_words: assert property ($past(st_q) == exc_pkg::ST_STACK && st_q == exc_pkg::ST_VEC |->
    $past(cnt_q) == 3'h7 && frame_q[2:0] == 3'h0) else $error("frame size or alignment");
  a_enter_active: assert property (vec_done |=> act_q[sel_q] && lr_we && lr_value[31:4] == 28'hFFFFFFF)
    else $error("entry not active");
  a_tail_chain: assert property ($past(st_q) == exc_pkg::ST_RUN && st_q == exc_pkg::ST_VEC |->
    $past(ret_hit)) else $error("chain without return");
  c_late: cover property (st_q == exc_pkg::ST_STACK ##1 st_q == exc_pkg::ST_STACK && $changed(sel_q));
  c_chain: cover property (ret_hit ##1 st_q == exc_pkg::ST_VEC);
  c_unstack: cover property (pop_end);
endmodule

// ### exc_params.svh
// constants of the exception controller: offsets, numbers, vectors, ranks, tokens
// assumes a 32-bit core, one clock, and a register bus at word-aligned offsets
// Function
// - each exception is inactive, pending, active, or active and pending
// - a new request during service leaves it active and pending; nesting allowed
// - reset stops the core; release fetches the reset vector, privileged thread mode
// - non-maskable interrupt: always enabled, priority -2, vector 0x08
// - unrecoverable fault: priority -1, vector 0x0C, beats configurable priorities
// - supervisor call 11 at 0x2C, deferred request 14 at 0x38, tick 15 at 0x3C
// - peripheral interrupts from number 16, vectors from 0x40 in steps of 4
// - asynchronous exceptions may let the core run on before entry
// - privileged software may disable configurable exceptions only
// - table base is zero after reset and relocatable by privileged software
// - lower priority value wins; fixed negative priorities beat configurable ones
// - configurable priorities are 0, 64, 128, 192; default 0
// - equal priority: smallest exception number served first
// - only strictly higher priority preempts; equal arrival just stays pending
// - handler done with qualifying pending exception: skip unstack, chain directly
// - higher arrival during stacking takes the vector fetch; earlier stays pending
// - entry needs priority above mask limit and above the running handler
// - stack eight words, double-word aligned, except for chained entries
// - handler start moves pending to active and writes the return token
// - in handler mode a load of bits 31..4 all set starts the return
// - tokens F1, F9, FD select stack and mode; others are reserved
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH
`define EXC_NUM      48
`define IRQ_NUM      32
`define IRQ_BASE     16
`define EXC_NMI      2
`define EXC_FAULT    3
`define EXC_SVC      11
`define EXC_DEFER    14
`define EXC_TICK     15
`define VEC_RESET    32'h0000_0004
`define RANK_NMI     3'h0
`define RANK_FAULT   3'h1
`define RANK_CFG     3'h2
`define RANK_NONE    3'h7
`define TOK_TOP      28'hFFF_FFFF
`define TOK_HANDLER  32'hFFFF_FFF1
`define TOK_MAIN     32'hFFFF_FFF9
`define TOK_PROC     32'hFFFF_FFFD
`define FRAME_LAST   3'h7
`define FRAME_BYTES  32'h0000_0020
`define TBL_RST      24'h00_0000
`define OFF_IRQ_EN   8'h00
`define OFF_PEND_SET 8'h04
`define OFF_PEND_CLR 8'h08
`define OFF_ACTIVE   8'h0C
`define OFF_SYS_CTRL 8'h10
`define OFF_SYS_EN   8'h14
`define OFF_SYS_PRIO 8'h18
`define OFF_TABLE    8'h1C
`define OFF_MASK     8'h20
`define OFF_STATUS   8'h24
`define OFF_IRQ_PRIO 8'h40
`define OFF_PRIO_END 8'h5C
`define PR_LSB       6
`define RESP_OK      2'h0
`define RESP_ERR     2'h2
`endif

// ### exc_pkg.sv
// types shared by the exception controller and its surroundings
// assumes nothing beyond the constants header
package exc_pkg;
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_RUN     = 3'b001,
    ST_STACK   = 3'b010,
    ST_VEC     = 3'b011,
    ST_UNSTACK = 3'b100
  } state_e;
  typedef enum logic [1:0] {
    MEM_PUSH = 2'b00,
    MEM_POP  = 2'b01,
    MEM_VEC  = 2'b10
  } mem_kind_e;
  typedef struct packed {
    mem_kind_e   kind;
    logic [31:0] addr;
  } mem_req_s;
  typedef struct packed {
    logic        process_stack_pointer;
    logic [31:0] value;
  } sp_upd_s;
endpackage

// ### exc_far_model.sv
// far side of the exception controller: pipeline boundary handshake and frame/vector memory
// assumes one clock shared with the controller and a seed given by the bench
`timescale 1ns/1ps
module exc_far_model (
  input  wire logic              aclk,      // core clock
  input  wire logic              aresetn,   // synchronous reset, low
  input  wire logic              take_req,  // entry wanted
  output      logic              take_ack,  // boundary reached
  input  wire logic              mem_valid, // frame or vector access
  input  wire exc_pkg::mem_req_s mem_req,   // kind and address
  output      logic              mem_ready, // access done
  output      logic [31:0]       mem_rdata  // vector word
);
  logic go;
  always @(posedge aclk) begin
    go = mem_valid && !mem_ready && ($urandom_range(0, 1) == 0);
    if (!aresetn) begin
      take_ack  <= 1'b0;
      mem_ready <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      // core keeps running a random while before it reaches a boundary
      take_ack  <= take_req && !take_ack && ($urandom_range(0, 2) == 0);
      mem_ready <= go;
      // vector words carry bit zero set; data is scrambled outside an answer
      mem_rdata <= go ? (mem_req.addr | 32'h0000_0001) : ~mem_rdata;
    end
  end
endmodule

// ### processor_exception_model_bench.sv
// self-checking bench of the exception controller with a random far side
// assumes the controller and the far model share clock and reset
`timescale 1ns/1ps
module processor_exception_model_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, irq, ret_value, msp_in, psp_in, mem_rdata, pc_value, lr_value;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp, resp;
  logic nmi_req, fault_req, svc_req, tick_req, take_req, take_ack, ret_req, mem_valid, mem_ready, pc_load;
  logic lr_we, sp_we, ret_done, handler_mode, priv, use_psp;
  logic [5:0] cur_exc;
  exc_pkg::mem_req_s mem_req;
  exc_pkg::sp_upd_s  sp_upd;
  int n_fail, n_checks, j, k;
  exc_ctrl      dut (.*);
  exc_far_model far (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] vec(input int n);
    return 32'(4 * n) | 32'h0000_0001;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h want %h", $time, act, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] p);
    logic done;
    done = 1'b0;
    awaddr <= a; awprot <= p; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin resp = bresp; done = 1'b1; end
    end
    if (!done) begin n_fail++; complete_run(); end
  endtask
  task automatic rd(input logic [31:0] a);
    logic done;
    done = 1'b0;
    araddr <= a; arprot <= 3'h1; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin resp = rresp; done = 1'b1; end
    end
    if (!done) begin n_fail++; complete_run(); end
  endtask
  // waits for a handler start (pc) or for the end of unstacking
  task automatic wait_ev(input bit pc);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 300 && !seen; n++) begin
      @(posedge aclk);
      if (pc ? pc_load === 1'b1 : ret_done === 1'b1) seen = 1'b1;
    end
    if (!seen) begin n_fail++; complete_run(); end
  endtask
  task automatic pulse(input logic [31:0] bits, input logic nm);
    irq <= bits; nmi_req <= nm;
    @(posedge aclk);
    irq <= 32'h0; nmi_req <= 1'b0;
  endtask
  task automatic no_entry();
    for (int n = 0; n < 30; n++) begin
      @(posedge aclk);
      chk(32'(pc_load), 32'h0);
    end
  endtask
  task automatic ret(input logic [31:0] tok);
    ret_req <= 1'b1; ret_value <= tok;
    @(posedge aclk);
    ret_req <= 1'b0; ret_value <= ~tok;
  endtask
  initial begin #2000000; n_fail++; complete_run(); end
  initial begin
    aresetn = 1'b0; awaddr = 0; awprot = 0; awvalid = 0; wdata = 0; wstrb = 4'hF; wvalid = 0; bready = 0;
    araddr = 0; arprot = 0; arvalid = 0; rready = 0; irq = 0; nmi_req = 0; fault_req = 0; svc_req = 0;
    tick_req = 0; ret_req = 0; ret_value = 0; n_fail = 0; n_checks = 0;
    void'($urandom(95096));
    msp_in = $urandom & 32'hFFFF_FFF8;
    psp_in = $urandom & 32'hFFFF_FFF8;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_ev(1); chk(pc_value, vec(1));
    chk(32'(priv), 32'h1);
    wr(32'h0000_0030, 32'h0, 3'h1); chk(32'(resp), 32'h2);
    wr(32'h0000_0000, 32'hFFFF_FFFF, 3'h0); chk(32'(resp), 32'h2);
    rd(32'h0000_0030); chk(32'(resp), 32'h2);
    wr(32'h0000_0000, 32'hFFFF_FFFF, 3'h1); chk(32'(resp), 32'h0);
    j = $urandom_range(0, 30);
    k = $urandom_range(j + 1, 31);
    pulse((32'h1 << j) | (32'h1 << k), 1'b0);
    wait_ev(1); chk(pc_value, vec(16 + j));
    chk(lr_value, 32'hFFFF_FFF9);
    chk(sp_upd.value, msp_in - 32'h0000_0020);
    chk(32'(cur_exc), 32'(16 + j));
    ret(32'hFFFF_FFF9);
    wait_ev(1); chk(pc_value, vec(16 + k));
    ret(32'hFFFF_FFF9);
    wait_ev(0); chk(32'(handler_mode), 32'h0);
    chk(sp_upd.value, msp_in + 32'h0000_0020);
    wr(32'h0000_0040, 32'h0000_00C0, 3'h1);
    pulse(32'h3, 1'b0);
    wait_ev(1); chk(pc_value, vec(17));
    pulse(32'h4, 1'b0);
    no_entry();
    rd(32'h0000_0004); chk(rdata, 32'h0000_0005);
    pulse(32'h0, 1'b1);
    wait_ev(1); chk(pc_value, vec(2));
    chk(lr_value, 32'hFFFF_FFF1);
    ret(32'hFFFF_FFF1);
    wait_ev(0); chk(32'(cur_exc), 32'd17);
    pulse(32'h2, 1'b0);
    rd(32'h0000_0004); chk(rdata, 32'h0000_0007);
    rd(32'h0000_000C); chk(rdata, 32'h0000_0002);
    ret(32'hFFFF_FFF9);
    wait_ev(1); chk(pc_value, vec(17));
    wr(32'h0000_0020, 32'h0000_0001, 3'h1); chk(32'(resp), 32'h0);
    wr(32'h0000_001C, 32'h0000_1200, 3'h1); chk(32'(resp), 32'h0);
    ret(32'hFFFF_FFF9);
    wait_ev(0); no_entry();
    rd(32'h0000_0004); chk(rdata, 32'h0000_0005);
    wr(32'h0000_0020, 32'h0000_0000, 3'h1);
    wait_ev(1); chk(pc_value, 32'h0000_1200 + vec(18));
    ret(32'hFFFF_FFFD);
    wait_ev(1); chk(pc_value, 32'h0000_1200 + vec(16));
    chk(lr_value, 32'hFFFF_FFFD);
    ret(32'hFFFF_FFFD);
    wait_ev(0); chk(32'(use_psp), 32'h1);
    chk(sp_upd.value, psp_in + 32'h0000_0020);
    complete_run();
  end
endmodule
